// [pkg/cwd_consts.svh]
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH

// Window count and reset split
`define CWD_NUM_WIN 7
`define CWD_NUM_IO_RST 2

// Register decode (byte address bits)
`define CWD_ADDR_HI 11
`define CWD_ADDR_TOP_LO 7
`define CWD_SLOT_HI 6
`define CWD_SLOT_LO 4
`define CWD_WORD_HI 3
`define CWD_WORD_LO 2
`define CWD_SLOT_SHARED 3'h7
`define CWD_WORD_CTRL 2'h0
`define CWD_WORD_START 2'h1
`define CWD_WORD_STOP 2'h2
`define CWD_WORD_OFFSET 2'h3
`define CWD_WORD_TIM0 2'h0
`define CWD_WORD_TIM1 2'h1
`define CWD_WORD_STATUS 2'h2

// Control word field positions
`define CWD_CTRL_EN 0
`define CWD_CTRL_HOST_IO 1
`define CWD_CTRL_CARD_IO 2
`define CWD_CTRL_AUTO 3
`define CWD_CTRL_W16 4
`define CWD_CTRL_MANUAL 5
`define CWD_CTRL_TSEL 6
`define CWD_CTRL_ATTR 7
`define CWD_CTRL_WPROT 8
`define CWD_CTRL_PAGE_LO 16
`define CWD_CTRL_PAGE_HI 23

// Address fields
`define CWD_PAGE_HI 31
`define CWD_PAGE_LO 24
`define CWD_MEM_HI 23
`define CWD_MEM_LO 12
`define CWD_IO_HI 15
`define CWD_IO_TOP_LO 16

// Reset values and the zero upper half for I/O decode
`define CWD_TIM_RST 24'h030303
`define CWD_STOP_RST 24'h000000
`define CWD_ZERO_ADDR 16'h0000

`endif

// [pkg/cwd_pkg.sv]
package cwd_pkg;
    typedef struct packed {
        logic enable;
        logic host_io;
        logic card_io;
        logic auto_size;
        logic width16;
        logic manual;
        logic timing_sel;
        logic attr;
        logic wprot;
        logic [7:0] page;
        logic [23:0] start;
        logic [23:0] stop;
        logic [25:0] offset;
    } cwd_win_t;

    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] command;
        logic [7:0] recovery;
    } cwd_timing_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic is_io;
        logic [31:0] addr;
    } cwd_host_req_t;

    typedef struct packed {
        logic valid;
        logic claim;
        logic card_cycle;
        logic drop_write;
        logic card_io;
        logic attr;
        logic width16;
        logic timing_sel;
        logic [2:0] win;
        logic [25:0] card_addr;
        cwd_timing_t timing;
    } cwd_card_rsp_t;
endpackage

// [rtl/cwd_sync.sv]
`timescale 1ns/1ps
`include "cwd_consts.svh"
module cwd_sync (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Pin side
    input wire logic i_pin,
    // Core side
    output logic o_level
);
    import cwd_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } cwd_sync_st_t;

    cwd_sync_st_t st;
    cwd_sync_st_t next_st;

    // Level follows only once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule // cwd_sync

// [rtl/cwd_window_match.sv]
`timescale 1ns/1ps
`include "cwd_consts.svh"
module cwd_window_match (
    // Window setup
    input cwd_pkg::cwd_win_t i_win,
    // Host request
    input wire logic [31:0] i_addr,
    input wire logic i_is_io,
    // Result
    output logic o_hit,
    output logic [25:0] o_card_addr
);
    import cwd_pkg::*;

    logic mem_hit;
    logic io_hit;
    logic [25:0] base;
    logic [26:0] sum;

    // Memory: page match then 4K-granular range inside it
    assign mem_hit = !i_is_io && !i_win.host_io && i_win.enable
        && (i_addr[`CWD_PAGE_HI:`CWD_PAGE_LO] == i_win.page)
        && (i_addr[`CWD_MEM_HI:`CWD_MEM_LO] >= i_win.start[`CWD_MEM_HI:`CWD_MEM_LO])
        && (i_addr[`CWD_MEM_HI:`CWD_MEM_LO] <= i_win.stop[`CWD_MEM_HI:`CWD_MEM_LO]);

    // I/O: byte range in the low 64K only
    assign io_hit = i_is_io && i_win.host_io && i_win.enable
        && (i_addr[`CWD_PAGE_HI:`CWD_IO_TOP_LO] == `CWD_ZERO_ADDR)
        && (i_addr[`CWD_IO_HI:0] >= i_win.start[`CWD_IO_HI:0])
        && (i_addr[`CWD_IO_HI:0] <= i_win.stop[`CWD_IO_HI:0]);

    // Host side type alone picks the decode; card type is free
    assign o_hit = mem_hit || io_hit;

    assign base = i_win.host_io ? {10'h000, i_addr[`CWD_IO_HI:0]}
                                : {2'h0, i_addr[`CWD_MEM_HI:0]};
    // Carry past the card's address width is dropped
    assign sum = {1'b0, base} + {1'b0, i_win.offset};
    assign o_card_addr = sum[25:0];
endmodule // cwd_window_match

// [rtl/cwd_top.sv]
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "cwd_consts.svh"
// Notes on behaviour
// - seven independent windows per socket
// - reset leaves two I/O, five memory windows
// - host and card cycle types chosen separately
// - disabled memory windows never claim
// - memory window lives in chosen 16M page
// - memory start on 4K boundary
// - memory end on 4K; claim inside range
// - card address is host address plus offset
// - manual 8/16 width overrides auto sizing
// - each window picks timing set 0 or 1
// - attribute select enabled per window
// - write-protected memory windows drop writes, reads pass
// - I/O start/end byte granular below 64K
// - each I/O window has own enable
// - auto size follows card's 16-bit line on card I/O windows only
module cwd_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Host decode request
    input cwd_pkg::cwd_host_req_t i_host_req,
    // Card pin
    input wire logic i_sixteen_bit_card,
    // Decode answer
    output cwd_pkg::cwd_card_rsp_t o_card_rsp
);
    import cwd_pkg::*;

    typedef struct packed {
        cwd_win_t [`CWD_NUM_WIN-1:0] win;
        cwd_timing_t [1:0] tim;
        logic [31:0] prdata;
        logic pslverr;
        cwd_card_rsp_t rsp;
    } cwd_top_st_t;

    cwd_top_st_t st;
    cwd_top_st_t next_st;

    logic card16;
    logic [`CWD_NUM_WIN-1:0] hit;
    logic [25:0] card_addr [`CWD_NUM_WIN];
    logic setup_ph;
    logic wr_ph;
    logic [2:0] slot;
    logic [1:0] word;
    logic top_ok;

    cwd_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_sixteen_bit_card),
        .o_level(card16)
    );

    // One comparator per window
    genvar g;
    generate
        for (g = 0; g < `CWD_NUM_WIN; g++) begin : g_win
            cwd_window_match u_match (
                .i_win(st.win[g]),
                .i_addr(i_host_req.addr),
                .i_is_io(i_host_req.is_io),
                .o_hit(hit[g]),
                .o_card_addr(card_addr[g])
            );
        end
    endgenerate

    assign setup_ph = i_psel && !i_penable;
    assign wr_ph = i_psel && i_penable && i_pwrite;
    assign slot = i_paddr[`CWD_SLOT_HI:`CWD_SLOT_LO];
    assign word = i_paddr[`CWD_WORD_HI:`CWD_WORD_LO];
    assign top_ok = (i_paddr[`CWD_ADDR_HI:`CWD_ADDR_TOP_LO] == 5'h00);

    function automatic logic [31:0] ctrl_word(input cwd_win_t w);
        logic [31:0] r;
        r = 32'h0;
        r[`CWD_CTRL_EN] = w.enable;
        r[`CWD_CTRL_HOST_IO] = w.host_io;
        r[`CWD_CTRL_CARD_IO] = w.card_io;
        r[`CWD_CTRL_AUTO] = w.auto_size;
        r[`CWD_CTRL_W16] = w.width16;
        r[`CWD_CTRL_MANUAL] = w.manual;
        r[`CWD_CTRL_TSEL] = w.timing_sel;
        r[`CWD_CTRL_ATTR] = w.attr;
        r[`CWD_CTRL_WPROT] = w.wprot;
        r[`CWD_CTRL_PAGE_HI:`CWD_CTRL_PAGE_LO] = w.page;
        return r;
    endfunction

    always_comb begin
        cwd_win_t sel;
        logic found;
        logic [2:0] idx;
        logic [25:0] sel_addr;
        logic drop;
        sel = st.win[0];
        found = 1'b0;
        idx = 3'h0;
        sel_addr = 26'h0;
        drop = 1'b0;
        next_st = st;

        // Read data and error latched in setup so access can finish at once
        if (setup_ph) begin
            next_st.prdata = 32'h0;
            next_st.pslverr = 1'b0;
            if (!top_ok) begin
                next_st.pslverr = 1'b1;
            end else if (slot != `CWD_SLOT_SHARED) begin
                case (word)
                    `CWD_WORD_CTRL: begin
                        next_st.prdata = ctrl_word(st.win[slot]);
                    end
                    `CWD_WORD_START: begin
                        next_st.prdata = {8'h00, st.win[slot].start};
                    end
                    `CWD_WORD_STOP: begin
                        next_st.prdata = {8'h00, st.win[slot].stop};
                    end
                    default: begin
                        next_st.prdata = {6'h00, st.win[slot].offset};
                    end
                endcase
            end else begin
                case (word)
                    `CWD_WORD_TIM0: begin
                        next_st.prdata = {8'h00, st.tim[0]};
                    end
                    `CWD_WORD_TIM1: begin
                        next_st.prdata = {8'h00, st.tim[1]};
                    end
                    `CWD_WORD_STATUS: begin
                        next_st.prdata = {25'h0, card16, st.rsp.claim, st.rsp.win,
                                          st.rsp.drop_write, st.rsp.width16};
                    end
                    default: begin
                        next_st.pslverr = 1'b1;
                    end
                endcase
            end
        end

        // Writes land in the access cycle; status is read only
        if (wr_ph && top_ok) begin
            if (slot != `CWD_SLOT_SHARED) begin
                case (word)
                    `CWD_WORD_CTRL: begin
                        next_st.win[slot].enable = i_pwdata[`CWD_CTRL_EN];
                        next_st.win[slot].host_io = i_pwdata[`CWD_CTRL_HOST_IO];
                        next_st.win[slot].card_io = i_pwdata[`CWD_CTRL_CARD_IO];
                        next_st.win[slot].auto_size = i_pwdata[`CWD_CTRL_AUTO];
                        next_st.win[slot].width16 = i_pwdata[`CWD_CTRL_W16];
                        next_st.win[slot].manual = i_pwdata[`CWD_CTRL_MANUAL];
                        next_st.win[slot].timing_sel = i_pwdata[`CWD_CTRL_TSEL];
                        next_st.win[slot].attr = i_pwdata[`CWD_CTRL_ATTR];
                        next_st.win[slot].wprot = i_pwdata[`CWD_CTRL_WPROT];
                        next_st.win[slot].page =
                            i_pwdata[`CWD_CTRL_PAGE_HI:`CWD_CTRL_PAGE_LO];
                    end
                    `CWD_WORD_START: begin
                        next_st.win[slot].start = i_pwdata[23:0];
                    end
                    `CWD_WORD_STOP: begin
                        next_st.win[slot].stop = i_pwdata[23:0];
                    end
                    default: begin
                        next_st.win[slot].offset = i_pwdata[25:0];
                    end
                endcase
            end else begin
                case (word)
                    `CWD_WORD_TIM0: begin
                        next_st.tim[0] = i_pwdata[23:0];
                    end
                    `CWD_WORD_TIM1: begin
                        next_st.tim[1] = i_pwdata[23:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Lowest index wins; overlaps are a software fault anyway
        for (int i = `CWD_NUM_WIN - 1; i >= 0; i--) begin
            if (hit[i]) begin
                found = 1'b1;
                idx = 3'(i);
                sel = st.win[i];
                sel_addr = card_addr[i];
            end
        end

        drop = found && !sel.host_io && sel.wprot && i_host_req.write;

        next_st.rsp.valid = i_host_req.valid;
        next_st.rsp.claim = i_host_req.valid && found;
        next_st.rsp.card_cycle = i_host_req.valid && found && !drop;
        next_st.rsp.drop_write = i_host_req.valid && drop;
        next_st.rsp.card_io = found && sel.card_io;
        next_st.rsp.attr = found && sel.attr;
        // Card pin decides only on auto I/O windows not forced manual
        if (sel.card_io && sel.auto_size && !sel.manual) begin
            next_st.rsp.width16 = found && card16;
        end else begin
            next_st.rsp.width16 = found && sel.width16;
        end
        next_st.rsp.timing_sel = found && sel.timing_sel;
        next_st.rsp.timing = st.tim[found && sel.timing_sel];
        next_st.rsp.win = idx;
        next_st.rsp.card_addr = found ? sel_addr : 26'h0;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st <= '0;
            for (int i = 0; i < `CWD_NUM_WIN; i++) begin
                // First windows start as I/O, the rest as memory
                st.win[i].host_io <= (i < `CWD_NUM_IO_RST);
                st.win[i].card_io <= (i < `CWD_NUM_IO_RST);
                st.win[i].stop <= `CWD_STOP_RST;
            end
            st.tim[0] <= `CWD_TIM_RST;
            st.tim[1] <= `CWD_TIM_RST;
        end else begin
            st <= next_st;
        end
    end

    // Zero wait state slave
    assign o_pready = 1'b1;
    assign o_prdata = st.prdata;
    assign o_pslverr = st.pslverr;
    assign o_card_rsp = st.rsp;
endmodule // cwd_top

// [tb/cwd_assertions.sv]
`timescale 1ns/1ps
module cwd_assertions (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Decode
    input cwd_pkg::cwd_host_req_t i_host_req,
    input wire logic i_sixteen_bit_card,
    input cwd_pkg::cwd_card_rsp_t o_card_rsp
);
    import cwd_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_req;
        i_host_req.valid;
    endsequence
    sequence s_read;
        i_host_req.valid && !i_host_req.write;
    endsequence
    sequence s_io_high;
        i_host_req.valid && i_host_req.is_io && i_host_req.addr[31:16] != 16'h0000;
    endsequence
    sequence s_bad;
        i_psel && !i_penable && (i_paddr[11:7] != 5'h00 || i_paddr[6:2] == 5'h1f);
    endsequence
    sequence s_good;
        i_psel && !i_penable && i_paddr[11:7] == 5'h00 && i_paddr[6:2] != 5'h1f;
    endsequence
    rsp_echo_a: assert property (s_req |=> o_card_rsp.valid)
        else $error("answer missing after request");
    rsp_idle_a: assert property (!i_host_req.valid |=> !o_card_rsp.valid)
        else $error("answer without request");
    claim_valid_a: assert property (o_card_rsp.claim |-> o_card_rsp.valid)
        else $error("claim outside a request");
    miss_zero_a: assert property (
        o_card_rsp.valid && !o_card_rsp.claim |-> o_card_rsp.card_addr == 26'h0 &&
        o_card_rsp.win == 3'h0) else $error("unclaimed answer not cleared");
    drop_cause_a: assert property (
        o_card_rsp.drop_write |-> o_card_rsp.claim && !o_card_rsp.card_cycle &&
        $past(i_host_req.write) && !$past(i_host_req.is_io)) else $error("bad drop");
    read_goes_a: assert property (
        s_read |=> o_card_rsp.card_cycle == o_card_rsp.claim && !o_card_rsp.drop_write)
        else $error("read not carried out");
    io_high_a: assert property (s_io_high |=> !o_card_rsp.claim)
        else $error("io above 64K claimed");
    win_index_a: assert property (o_card_rsp.claim |-> o_card_rsp.win < 3'h7)
        else $error("window index out of range");
    bad_addr_a: assert property (s_bad |=> o_pslverr)
        else $error("unmapped access not refused");
    good_addr_a: assert property (s_good |=> !o_pslverr && o_pready)
        else $error("mapped access refused");
endmodule // cwd_assertions

bind cwd_top cwd_assertions i_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_host_req(i_host_req),
    .i_sixteen_bit_card(i_sixteen_bit_card), .o_card_rsp(o_card_rsp)
);

// [tb/cwd_card_model.sv]
`timescale 1ns/1ps
module cwd_card_model (
    // Clock
    input wire logic i_core_clk,
    // Level asked by the bench
    input wire logic i_want16,
    // Card pin
    output logic o_sixteen_bit_card
);
    initial o_sixteen_bit_card = 1'b0;
    // Moves only after an edge, so the synchroniser sees a clean step
    always @(posedge i_core_clk) begin
        o_sixteen_bit_card <= i_want16;
    end
endmodule // cwd_card_model

// [tb/card_window_decoder_tb_top.sv]
`timescale 1ns/1ps
module card_window_decoder_tb_top;
    import cwd_pkg::*;
    logic i_core_clk = 0;
    logic i_rst_n = 0;
    logic psel = 0;
    logic pen = 0;
    logic pwr = 0;
    logic [11:0] padr = 0;
    logic [31:0] pwd = 0;
    logic [31:0] prd;
    logic rdy;
    logic err;
    logic pin;
    logic want = 0;
    cwd_host_req_t req = '0;
    cwd_card_rsp_t rsp;
    logic [31:0] ctl [7];
    logic [31:0] sta [7];
    logic [31:0] stp [7];
    logic [31:0] ofs [7];
    logic [31:0] tim [2];
    logic [31:0] q;
    logic e;
    int errors = 0;
    int n_checks = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    cwd_card_model i_card (.i_core_clk(i_core_clk), .i_want16(want), .o_sixteen_bit_card(pin));
    cwd_top i_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .i_host_req(req), .i_sixteen_bit_card(pin), .o_card_rsp(rsp)
    );
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge i_core_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            results();
        end
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("rdata", {e, q}, {1'b0, x});
    endtask
    task automatic prog(input int k);
        apb(1'b1, 12'(k * 16), ctl[k]);
        apb(1'b1, 12'(k * 16 + 4), sta[k]);
        apb(1'b1, 12'(k * 16 + 8), stp[k]);
        apb(1'b1, 12'(k * 16 + 12), ofs[k]);
        rdc(12'(k * 16), ctl[k]);
    endtask
    task automatic host(input logic [31:0] a, input logic io, input logic w);
        int h;
        logic [31:0] c;
        logic [25:0] ca;
        logic dr;
        h = -1;
        @(posedge i_core_clk);
        req <= {1'b1, w, io, a};
        // Walk downwards so the lowest window wins
        for (int k = 6; k >= 0; k--) begin
            c = ctl[k];
            if (c[0] && (io ? (c[1] && a[31:16] == 16'h0 && a[15:0] >= sta[k][15:0] &&
                a[15:0] <= stp[k][15:0]) : (!c[1] && a[31:24] == c[23:16] &&
                a[23:12] >= sta[k][23:12] && a[23:12] <= stp[k][23:12]))) h = k;
        end
        @(posedge i_core_clk);
        req.valid <= 1'b0;
        #1;
        if (h < 0) begin
            chk("miss", {rsp[60:57], rsp.win, rsp.card_addr}, 64'h1 << 32);
        end else begin
            c = ctl[h];
            ca = io ? a[15:0] + ofs[h][25:0] : a[23:0] + ofs[h][25:0];
            dr = w & c[8] & !c[1];
            chk("hit", rsp, {2'b11, !dr, dr, c[2], c[7], (c[2] & c[3] & !c[5]) ? want : c[4],
                c[6], h[2:0], ca, tim[c[6]][23:0]});
        end
    endtask
    initial begin
        int r;
        int w;
        logic [31:0] b;
        logic [31:0] a;
        logic io;
        void'($urandom(32'h514fe99b));
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 7; k++) rdc(12'(k * 16), k < 2 ? 32'h6 : 32'h0);
        for (int k = 0; k < 2; k++) begin
            rdc(12'(112 + 4 * k), 32'h030303);
            apb(1'b0, k ? 12'h80 : 12'h7c, 32'h0);
            chk("error", {e, q}, {1'b1, 32'h0});
            tim[k] = $urandom & 32'hffffff;
            apb(1'b1, 12'(112 + 4 * k), tim[k]);
        end
        apb(1'b1, 12'h64, 32'hffffffff);
        rdc(12'h64, 32'h00ffffff);
        for (int k = 0; k < 7; k++) begin
            r = $urandom;
            b = $urandom;
            ctl[k] = {8'h0, b[31:24], 7'h0, r[8:3], k[1], k[0], k != 5};
            if (k == 3) ctl[k][5:3] = 3'b001;
            if (k == 0) ctl[k][8] = 1'b1;
            // Each window in its own region, so none overlaps another
            b = ctl[k][1] ? {16'h0, 4'(k), 12'h0} : {8'h0, 4'(k), 20'h0};
            a = ctl[k][1] ? 32'h7ff : 32'h7ffff;
            sta[k] = b + (r & a);
            stp[k] = sta[k] + ($urandom & a);
            ofs[k] = $urandom & 32'h3ffffff;
            prog(k);
        end
        for (int bt = 0; bt < 4; bt++) begin
            if (bt == 2) ctl[3][5] = 1'b1;
            if (bt == 3) ctl[1][0] = 1'b0;
            if (bt >= 2) prog(bt == 2 ? 3 : 1);
            want <= bt[0];
            repeat (8) @(posedge i_core_clk);
            apb(1'b0, 12'h78, 32'h0);
            chk("pin", {e, q[6]}, {1'b0, bt[0]});
            for (int i = 0; i < 60; i++) begin
                w = $urandom % 8;
                a = $urandom;
                io = 1'($urandom);
                if (w < 7) begin
                    io = ctl[w][1];
                    b = $urandom % (stp[w] - sta[w] + 1);
                    a = io ? {16'h0, sta[w][15:0] + b[15:0]} :
                        {ctl[w][23:16], sta[w][23:0] + b[23:0]};
                end
                host(a, io, 1'($urandom));
            end
        end
        results();
    end
endmodule // card_window_decoder_tb_top
